// file: design/global_status_register_bank.sv
// read-only global status register bank of a dual-PLL clock translator
// assumes a register port in mclk_in domain, and load events from the boot sequencer
`timescale 1ns/1ps
`include "status_bank_defs.svh"

module global_status_register_bank (
  input wire logic mclk_in, // core clock, 25 MHz
  input wire logic reset_n_in, // synchronous reset, active low
  input wire status_bank_pkg::gen_input_t gpio_pin_in, // raw multipurpose pin levels
  input wire status_bank_pkg::gen_input_t gpio_is_input_in, // pin set as general input
  input wire status_bank_pkg::irq_vec_t irq_source_in, // individual status bits
  input wire status_bank_pkg::irq_vec_t irq_enable_in, // per-source enables
  input wire status_bank_pkg::cal_code_t pll0_cal_code_in, // pll0 calibration code
  input wire status_bank_pkg::cal_code_t pll1_cal_code_in, // pll1 calibration code
  input wire logic cfg_rom_load_done_in, // pulse: memory read cycle finished
  input wire logic boot_load_failed_in, // pulse: memory read failed
  input wire logic cfg_rom_crc_err_in, // pulse: memory read but crc bad
  input wire status_bank_pkg::reg_addr_t reg_addr_in, // register address
  input wire logic reg_rd_in, // read strobe
  input wire logic reg_wr_in, // write strobe, ignored
  input wire status_bank_pkg::reg_byte_t reg_wdata_in, // write data, ignored
  output status_bank_pkg::reg_byte_t reg_rdata_out, // read data, registered
  output logic reg_rvalid_out, // read data valid pulse
  output logic irq_out_n_out, // interrupt line drive value
  output logic irq_out_n_oe_out, // low while line is driven
  output logic serial_port_lock_out // serial register port locked
);
  import status_bank_pkg::*;

  gen_input_t pin_meta_reg;
  gen_input_t pin_meta_next;
  gen_input_t pin_sync_reg;
  gen_input_t pin_sync_next;
  logic irq_reg;
  logic irq_next;
  logic done_reg;
  logic done_next;
  logic fail_reg;
  logic fail_next;
  logic crc_err_reg;
  logic crc_err_next;
  reg_byte_t rdata_reg;
  reg_byte_t rdata_next;
  logic rvalid_reg;
  logic rvalid_next;
  reg_byte_t read_mux;
  reg_sel_e sel;

  // address decode, shared by read mux and assertions
  function automatic reg_sel_e decode(input reg_addr_t a);
    case (a)
      `ADDR_GEN_INPUT: decode = SEL_GEN_INPUT;
      `ADDR_IRQ_SUMMARY: decode = SEL_IRQ_SUMMARY;
      `ADDR_PLL0_CAL: decode = SEL_PLL0_CAL;
      `ADDR_PLL1_CAL: decode = SEL_PLL1_CAL;
      `ADDR_BOOT_FAIL: decode = SEL_BOOT_FAIL;
      `ADDR_LOAD_STATUS: decode = SEL_LOAD_STATUS;
      default: decode = SEL_NONE;
    endcase
  endfunction

  // pin synchroniser, two stages
  always_comb begin
    pin_meta_next = gpio_pin_in;
    pin_sync_next = pin_meta_reg;
  end

  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      pin_meta_reg <= `GEN_ZERO;
      pin_sync_reg <= `GEN_ZERO;
    end else begin
      pin_meta_reg <= pin_meta_next;
      pin_sync_reg <= pin_sync_next;
    end
  end

  // interrupt summary and sticky load flags
  always_comb begin
    irq_next = |(irq_source_in & irq_enable_in);
    fail_next = fail_reg | boot_load_failed_in;
    crc_err_next = crc_err_reg | cfg_rom_crc_err_in;
    done_next = done_reg | cfg_rom_load_done_in;
  end

  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      irq_reg <= `FLAG_CLEAR;
      fail_reg <= `FLAG_CLEAR;
      crc_err_reg <= `FLAG_CLEAR;
      done_reg <= `FLAG_CLEAR;
    end else begin
      irq_reg <= irq_next;
      fail_reg <= fail_next;
      crc_err_reg <= crc_err_next;
      done_reg <= done_next;
    end
  end

  // open-drain line: value always low, enable low while asserted
  assign irq_out_n_out = `FLAG_CLEAR;
  assign irq_out_n_oe_out = ~irq_reg;
  assign serial_port_lock_out = crc_err_reg;

  // read mux, reserved bits read zero; writes never reach state
  always_comb begin
    sel = decode(reg_addr_in);
    read_mux = `BYTE_ZERO;
    case (sel)
      SEL_GEN_INPUT: read_mux[`GEN_INPUT_PINS-1:0] = pin_sync_reg & gpio_is_input_in;
      SEL_IRQ_SUMMARY: read_mux[`BIT_IRQ_SUMMARY] = irq_reg;
      SEL_PLL0_CAL: read_mux[`CAL_BITS-1:0] = pll0_cal_code_in;
      SEL_PLL1_CAL: read_mux[`CAL_BITS-1:0] = pll1_cal_code_in;
      SEL_BOOT_FAIL: read_mux[`BIT_BOOT_FAIL] = fail_reg;
      SEL_LOAD_STATUS: begin
        read_mux[`BIT_LOAD_DONE] = done_reg;
        read_mux[`BIT_CHECK_OK] = ~crc_err_reg;
      end
      default: read_mux = `BYTE_ZERO;
    endcase
    rdata_next = reg_rd_in ? read_mux : rdata_reg;
    rvalid_next = reg_rd_in;
  end

  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      rdata_reg <= `BYTE_ZERO;
      rvalid_reg <= `FLAG_CLEAR;
    end else begin
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign reg_rdata_out = rdata_reg;
  assign reg_rvalid_out = rvalid_reg;

  // checks
  a_gen_input_read: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    reg_rd_in && decode(reg_addr_in) == SEL_GEN_INPUT
    |=> reg_rdata_out == {`GEN_ZERO, $past(pin_sync_reg & gpio_is_input_in)})
    else $error("general input read wrong");

  a_irq_assert_low: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    |(irq_source_in & irq_enable_in) |=> !irq_out_n_oe_out && !irq_out_n_out)
    else $error("interrupt line not driven low");

  a_irq_release: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    !(|(irq_source_in & irq_enable_in)) |=> irq_out_n_oe_out)
    else $error("interrupt line not released");

  a_summary_matches: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    reg_rd_in && decode(reg_addr_in) == SEL_IRQ_SUMMARY
    |=> reg_rdata_out[`BIT_IRQ_SUMMARY] == !$past(irq_out_n_oe_out))
    else $error("summary bit disagrees with line");

  a_fail_sticky: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    boot_load_failed_in |=> fail_reg [*8])
    else $error("boot failure flag did not stick");

  a_check_flag: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    reg_rd_in && decode(reg_addr_in) == SEL_LOAD_STATUS
    |=> reg_rdata_out[`BIT_CHECK_OK] == !$past(crc_err_reg))
    else $error("check flag wrong");

  a_port_locked: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    cfg_rom_crc_err_in |=> serial_port_lock_out ##1 serial_port_lock_out)
    else $error("serial port not locked after crc error");

  a_done_sticky: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    $fell(done_reg) |-> $past(!reset_n_in))
    else $error("load done flag cleared without reset");

  a_cal_read: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    reg_rd_in && decode(reg_addr_in) == SEL_PLL1_CAL
    |=> reg_rdata_out == {2'b00, $past(pll1_cal_code_in)})
    else $error("pll1 calibration read wrong");

  a_read_no_effect: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    (reg_rd_in || reg_wr_in) && !cfg_rom_load_done_in && !boot_load_failed_in
    && !cfg_rom_crc_err_in |=> $stable(done_reg) && $stable(fail_reg) && $stable(crc_err_reg))
    else $error("access changed a flag");

  a_write_ignored: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    reg_wr_in && !reg_rd_in |=> !reg_rvalid_out && $stable(reg_rdata_out))
    else $error("write disturbed the read port");

  a_pll0_cal_read: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    reg_rd_in && decode(reg_addr_in) == SEL_PLL0_CAL
    |=> reg_rdata_out == {2'b00, $past(pll0_cal_code_in)})
    else $error("pll0 calibration read wrong");

  a_fail_flag_read: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    reg_rd_in && decode(reg_addr_in) == SEL_BOOT_FAIL
    |=> reg_rdata_out[`BIT_BOOT_FAIL] == $past(fail_reg))
    else $error("boot failure read wrong");

  a_done_read: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
    reg_rd_in && decode(reg_addr_in) == SEL_LOAD_STATUS
    |=> reg_rdata_out[`BIT_LOAD_DONE] == $past(done_reg))
    else $error("load done read wrong");

  c_irq_asserted: cover property (@(posedge mclk_in) disable iff (!reset_n_in)
    $fell(irq_out_n_oe_out));
  c_crc_lock: cover property (@(posedge mclk_in) disable iff (!reset_n_in)
    $rose(serial_port_lock_out));
  c_done_read: cover property (@(posedge mclk_in) disable iff (!reset_n_in)
    done_reg && reg_rd_in && decode(reg_addr_in) == SEL_LOAD_STATUS);
  c_fail_read: cover property (@(posedge mclk_in) disable iff (!reset_n_in)
    fail_reg && reg_rd_in && decode(reg_addr_in) == SEL_BOOT_FAIL);
  c_write_seen: cover property (@(posedge mclk_in) disable iff (!reset_n_in)
    reg_wr_in && !reg_rd_in);
endmodule

// file: design/status_bank_defs.svh
// register offsets, field positions and reset values of the status bank
// assumes inclusion by the bank package and the bank module
`ifndef STATUS_BANK_DEFS_SVH
`define STATUS_BANK_DEFS_SVH

// register offsets on the internal register port
`define ADDR_GEN_INPUT 16'h0219
`define ADDR_IRQ_SUMMARY 16'h021A
`define ADDR_PLL0_CAL 16'h021C
`define ADDR_PLL1_CAL 16'h021D
`define ADDR_BOOT_FAIL 16'h021E
`define ADDR_LOAD_STATUS 16'h021F

// field positions
`define BIT_IRQ_SUMMARY 0
`define BIT_BOOT_FAIL 0
`define BIT_LOAD_DONE 0
`define BIT_CHECK_OK 3

// widths and reset values
`define GEN_INPUT_PINS 4
`define IRQ_SOURCES 8
`define CAL_BITS 6
`define BYTE_ZERO 8'h00
`define GEN_ZERO 4'h0
`define FLAG_CLEAR 1'b0
`define FLAG_SET 1'b1

`endif

// file: design/status_bank_pkg.sv
// types shared by the status bank and its surroundings
// assumes status_bank_defs.svh sits beside it
`include "status_bank_defs.svh"

package status_bank_pkg;
  typedef logic [15:0] reg_addr_t;
  typedef logic [7:0] reg_byte_t;
  typedef logic [`GEN_INPUT_PINS-1:0] gen_input_t;
  typedef logic [`IRQ_SOURCES-1:0] irq_vec_t;
  typedef logic [`CAL_BITS-1:0] cal_code_t;

  // register selected by an address
  typedef enum logic [2:0] {
    SEL_NONE = 3'h0,
    SEL_GEN_INPUT = 3'h1,
    SEL_IRQ_SUMMARY = 3'h3,
    SEL_PLL0_CAL = 3'h2,
    SEL_PLL1_CAL = 3'h6,
    SEL_BOOT_FAIL = 3'h7,
    SEL_LOAD_STATUS = 3'h5
  } reg_sel_e;
endpackage

// file: tb/host_reader.sv
// host model: reads and writes the status bank's register port
// assumes the bank samples requests on the rising edge of mclk_in
`timescale 1ns/1ps
module host_reader (
  input wire logic mclk_in, // core clock
  input wire logic reg_rvalid_in, // read data valid pulse
  input wire status_bank_pkg::reg_byte_t reg_rdata_in, // read data
  output status_bank_pkg::reg_addr_t reg_addr_out, // register address
  output logic reg_rd_out, // read strobe
  output logic reg_wr_out, // write strobe
  output status_bank_pkg::reg_byte_t reg_wdata_out // write data
);
  import status_bank_pkg::*;
  // idle bus at time zero
  initial begin
    reg_addr_out = 16'h0000;
    reg_rd_out = 1'b0;
    reg_wr_out = 1'b0;
    reg_wdata_out = 8'h00;
  end
  // one-cycle read strobe, then a bounded wait for valid
  task automatic rd(input reg_addr_t a, output reg_byte_t d, output bit ok);
    int n;
    @(negedge mclk_in);
    reg_addr_out = a;
    reg_rd_out = 1'b1;
    @(negedge mclk_in);
    reg_rd_out = 1'b0;
    ok = 1'b0;
    d = 8'h00;
    for (n = 0; n < 4 && !ok; n++) begin
      if (reg_rvalid_in === 1'b1) begin
        d = reg_rdata_in;
        ok = 1'b1;
      end else begin
        @(negedge mclk_in);
      end
    end
  endtask
  // write strobe carrying zero in every bit
  task automatic wr(input reg_addr_t a);
    @(negedge mclk_in);
    reg_addr_out = a;
    reg_wdata_out = 8'h00;
    reg_wr_out = 1'b1;
    @(negedge mclk_in);
    reg_wr_out = 1'b0;
  endtask
endmodule

// file: tb/global_status_register_bank_tb_top.sv
// testbench of the status bank: register reads against expected values
// assumes host_reader and the bank's package are compiled before it
`timescale 1ns/1ps
module global_status_register_bank_tb_top;
  import status_bank_pkg::*;
  logic mclk_in, reset_n_in, done_ev, fail_ev, crc_ev, rd, wr, rvalid, irq_n, irq_oe, lock;
  gen_input_t pins, is_in;
  irq_vec_t src, en;
  cal_code_t cal0, cal1;
  reg_addr_t addr;
  reg_byte_t wdata, rdata;
  int fail_count = 0;
  int tests_run = 0;
  global_status_register_bank dut_u (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
    .gpio_pin_in(pins), .gpio_is_input_in(is_in), .irq_source_in(src), .irq_enable_in(en),
    .pll0_cal_code_in(cal0), .pll1_cal_code_in(cal1), .cfg_rom_load_done_in(done_ev),
    .boot_load_failed_in(fail_ev), .cfg_rom_crc_err_in(crc_ev), .reg_addr_in(addr),
    .reg_rd_in(rd), .reg_wr_in(wr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
    .reg_rvalid_out(rvalid), .irq_out_n_out(irq_n), .irq_out_n_oe_out(irq_oe),
    .serial_port_lock_out(lock));
  host_reader host_u (.mclk_in(mclk_in), .reg_rvalid_in(rvalid), .reg_rdata_in(rdata),
    .reg_addr_out(addr), .reg_rd_out(rd), .reg_wr_out(wr), .reg_wdata_out(wdata));
  // clock of 40 ns period
  initial begin
    mclk_in = 1'b0;
    forever #20 mclk_in = ~mclk_in;
  end
  // verdict and end of run
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // compare tasks for bytes and single bits
  task automatic chk_byte(input reg_byte_t e, input reg_byte_t g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value at %0t: byte %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_bit(input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value at %0t: bit %b expected %b", $time, g, e);
    end
  endtask
  // read one register and compare, stopping on a missing answer
  task automatic rdchk(input reg_addr_t a, input reg_byte_t e);
    reg_byte_t d;
    bit ok;
    host_u.rd(a, d, ok);
    if (!ok) begin
      fail_count++;
      $display("wrong value at %0t: no read answer", $time);
      print_verdict();
    end else begin
      chk_byte(e, d);
    end
  endtask
  // main sequence
  initial begin
    reset_n_in = 1'b0;
    {done_ev, fail_ev, crc_ev} = 3'h0;
    pins = 4'h0;
    is_in = 4'h0;
    src = 8'h00;
    en = 8'h00;
    cal0 = 6'h00;
    cal1 = 6'h00;
    repeat (20) @(negedge mclk_in);
    reset_n_in = 1'b1;
    rdchk(16'h021F, 8'h08);
    rdchk(16'h021E, 8'h00);
    chk_bit(1'b0, lock);
    pins = 4'hA;
    is_in = 4'hF;
    repeat (3) @(negedge mclk_in);
    rdchk(16'h0219, 8'h0A);
    is_in = 4'h3;
    rdchk(16'h0219, 8'h02);
    cal0 = 6'h2A;
    cal1 = 6'h15;
    rdchk(16'h021C, 8'h2A);
    rdchk(16'h021D, 8'h15);
    src = 8'h84;
    en = 8'h04;
    repeat (2) @(negedge mclk_in);
    chk_bit(1'b0, irq_oe);
    chk_bit(1'b0, irq_n);
    rdchk(16'h021A, 8'h01);
    en = 8'h7B;
    repeat (2) @(negedge mclk_in);
    chk_bit(1'b1, irq_oe);
    rdchk(16'h021A, 8'h00);
    crc_ev = 1'b1;
    @(negedge mclk_in);
    crc_ev = 1'b0;
    @(negedge mclk_in);
    chk_bit(1'b1, lock);
    rdchk(16'h021F, 8'h00);
    {done_ev, fail_ev} = 2'h3;
    @(negedge mclk_in);
    {done_ev, fail_ev} = 2'h0;
    rdchk(16'h021F, 8'h01);
    rdchk(16'h021E, 8'h01);
    host_u.wr(16'h021F);
    host_u.wr(16'h021E);
    rdchk(16'h021F, 8'h01);
    rdchk(16'h021E, 8'h01);
    rdchk(16'h021B, 8'h00);
    reset_n_in = 1'b0;
    repeat (3) @(negedge mclk_in);
    reset_n_in = 1'b1;
    rdchk(16'h021F, 8'h08);
    chk_bit(1'b0, lock);
    print_verdict();
  end
endmodule
